// *** design/cag_pkg.sv ***
// Shared constants and types for the CPU address generation block.
package cag_pkg;

  // Operand addressing modes accepted on the request port.
  typedef enum logic [3:0] {
    CAG_MODE_DIRECT,
    CAG_MODE_SHORT,
    CAG_MODE_SHORT_WORD,
    CAG_MODE_SFR,
    CAG_MODE_SFR_WORD,
    CAG_MODE_IND_DE,
    CAG_MODE_IND_HL,
    CAG_MODE_BASED,
    CAG_MODE_BASED_IDX_B,
    CAG_MODE_BASED_IDX_C,
    CAG_MODE_STACK,
    CAG_MODE_TABLE
  } cag_mode_type;

  // Implied-accumulator write-back kinds.
  typedef enum logic [2:0] {
    CAG_IMP_MULTIPLY,
    CAG_IMP_DIVIDE,
    CAG_IMP_BCD_ADD,
    CAG_IMP_BCD_SUB,
    CAG_IMP_ROT_LEFT,
    CAG_IMP_ROT_RIGHT
  } cag_imp_type;

  // Register codes, in opcode order.
  localparam logic [2:0] CAG_REG_X = 3'h0;
  localparam logic [2:0] CAG_REG_A = 3'h1;
  localparam logic [2:0] CAG_REG_C = 3'h2;
  localparam logic [2:0] CAG_REG_B = 3'h3;
  localparam logic [2:0] CAG_REG_E = 3'h4;
  localparam logic [2:0] CAG_REG_D = 3'h5;
  localparam logic [2:0] CAG_REG_L = 3'h6;
  localparam logic [2:0] CAG_REG_H = 3'h7;
  localparam logic [1:0] CAG_PAIR_AX = 2'h0;
  localparam logic [1:0] CAG_PAIR_DE = 2'h2;
  localparam logic [1:0] CAG_PAIR_HL = 2'h3;
  localparam int CAG_NUM_BANKS = 4;
  localparam int CAG_NUM_REGS = 8;

  // Address map figures.
  localparam logic [15:0] CAG_TABLE_BASE = 16'h0040;
  localparam logic [7:0] CAG_SHORT_SPLIT = 8'h20;
  localparam logic [6:0] CAG_SHORT_HIGH = 7'h7f;
  localparam logic [7:0] CAG_SFR_HIGH = 8'hff;
  localparam logic [7:0] CAG_SFR_GAP_LO = 8'hd0;
  localparam logic [7:0] CAG_SFR_GAP_HI = 8'hdf;
  localparam logic [15:0] CAG_HRAM_LO = 16'hfb00;
  localparam logic [15:0] CAG_HRAM_HI = 16'hfeff;
  localparam logic [15:0] CAG_WIN_LO = 16'h8000;
  localparam logic [15:0] CAG_WIN_HI = 16'hbfff;
  localparam logic [16:0] CAG_WIN_PHYS_BASE = 17'h08000;
  localparam int CAG_WIN_BITS = 14;

  // Reset values.
  localparam logic [2:0] CAG_BANK_RESET = 3'h0;
  localparam logic [15:0] CAG_PC_RESET = 16'h0000;
  localparam logic [7:0] CAG_REG_RESET = 8'h00;

endpackage

// *** design/cag_bank_map.sv ***
// Logical to physical ROM address mapping through the banked window.
`timescale 1ns/10ps
module cag_bank_map
  import cag_pkg::*;
(
  // Logical side
  input wire logic [15:0] logical_addr,
  input wire logic [2:0] bank_sel,
  // Physical side
  output logic [16:0] phys_addr,
  output logic in_window
);

  // Only the two low bank bits select a bank; higher codes are prohibited.
  always_comb
  begin
    in_window = (logical_addr >= CAG_WIN_LO) && (logical_addr <= CAG_WIN_HI);
    if (in_window)
    begin
      phys_addr = CAG_WIN_PHYS_BASE +
        {1'b0, bank_sel[1:0], logical_addr[CAG_WIN_BITS-1:0]};
    end
    else
    begin
      phys_addr = {1'b0, logical_addr};
    end
  end

endmodule

// *** design/cag_addr_gen.sv ***
// Address generation unit: branch targets, operand addresses, ROM banking.
`timescale 1ns/10ps
module cag_addr_gen
  import cag_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register bank flags
  input wire logic reg_bank_sel_lo,
  input wire logic reg_bank_sel_hi,
  // Operand address request
  input wire logic req_valid,
  input wire cag_pkg::cag_mode_type req_mode,
  input wire logic [7:0] req_opcode,
  input wire logic [15:0] req_imm16,
  input wire logic [15:0] stack_pointer,
  // Operand address answer
  output logic addr_valid_q,
  output logic [15:0] addr_q,
  output logic [16:0] addr_phys_q,
  output logic addr_fault_q,
  // Register file access
  input wire logic reg_wr_valid,
  input wire logic [2:0] reg_wr_code,
  input wire logic [7:0] reg_wr_data,
  input wire logic [2:0] reg_rd_code,
  output logic [7:0] reg_rd_data_q,
  // Implied accumulator traffic
  input wire logic imp_wr_valid,
  input wire cag_pkg::cag_imp_type imp_wr_op,
  input wire logic [15:0] imp_wr_data,
  output logic [7:0] acc_byte_q,
  output logic [15:0] acc_word_pair_q,
  // Program counter control
  input wire logic jump_instr,
  input wire logic table_load_valid,
  input wire logic [15:0] table_data,
  input wire logic pc_step_valid,
  input wire logic [2:0] pc_step_len,
  output logic [15:0] program_counter_q,
  output logic [16:0] fetch_phys_q,
  output logic fetch_fault_q,
  // Memory bank select register
  input wire logic bank_wr_valid,
  input wire logic [7:0] bank_wr_data,
  output logic [2:0] bank_q
);

  import cag_pkg::*;

  logic [7:0] regs_q [CAG_NUM_BANKS*CAG_NUM_REGS];
  logic [1:0] rbank;
  logic [15:0] pair_ax;
  logic [15:0] base_pair;
  logic [15:0] second_ptr_pair;
  logic [15:0] addr_d;
  logic fault_d;
  logic [16:0] addr_phys_d;
  logic [16:0] fetch_phys_d;
  logic [15:0] pc_d;
  logic [15:0] fetch_end;
  logic fetch_fault_d;
  logic imp_word;

  // Byte index of a register in the flat register file.
  function automatic int reg_index(input logic [1:0] bnk, input logic [2:0] c);
    reg_index = int'({bnk, c});
  endfunction

  // Reads a register pair: high byte is the odd code, low the even one.
  function automatic logic [15:0] read_pair(input logic [1:0] bnk,
                                            input logic [1:0] p);
    read_pair = {regs_q[reg_index(bnk, {p, 1'b1})],
                 regs_q[reg_index(bnk, {p, 1'b0})]};
  endfunction

  // The two bank flags choose one of four register banks.
  assign rbank = {reg_bank_sel_hi, reg_bank_sel_lo};
  assign pair_ax = read_pair(rbank, CAG_PAIR_AX);
  assign base_pair = read_pair(rbank, CAG_PAIR_HL);
  assign second_ptr_pair = read_pair(rbank, CAG_PAIR_DE);
  assign imp_word = (imp_wr_op == CAG_IMP_MULTIPLY) ||
                    (imp_wr_op == CAG_IMP_DIVIDE);

  // Register file, one flop per byte. An implied write beats a plain write
  // to the same byte, since the accumulator result is the later one.
  for (genvar g = 0; g < CAG_NUM_BANKS*CAG_NUM_REGS; g++)
  begin : g_reg
    localparam logic [1:0] GB = 2'(g / CAG_NUM_REGS);
    localparam logic [2:0] GC = 3'(g % CAG_NUM_REGS);
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        regs_q[g] <= CAG_REG_RESET;
      end
      else if (imp_wr_valid && GB == rbank && GC == CAG_REG_A)
      begin
        regs_q[g] <= imp_word ? imp_wr_data[15:8] : imp_wr_data[7:0];
      end
      else if (imp_wr_valid && imp_word && GB == rbank && GC == CAG_REG_X)
      begin
        regs_q[g] <= imp_wr_data[7:0];
      end
      else if (reg_wr_valid && GB == rbank && GC == reg_wr_code)
      begin
        regs_q[g] <= reg_wr_data;
      end
    end
  end

  // Register and accumulator read-out, one cycle behind the file.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reg_rd_data_q <= CAG_REG_RESET;
      acc_byte_q <= CAG_REG_RESET;
      acc_word_pair_q <= {CAG_REG_RESET, CAG_REG_RESET};
    end
    else
    begin
      reg_rd_data_q <= regs_q[reg_index(rbank, reg_rd_code)];
      acc_byte_q <= regs_q[reg_index(rbank, CAG_REG_A)];
      acc_word_pair_q <= pair_ax;
    end
  end

  // Effective address per mode; faults flag forms the hardware refuses.
  always_comb
  begin
    addr_d = req_imm16;
    fault_d = 1'b0;
    unique case (req_mode)
      CAG_MODE_DIRECT: addr_d = req_imm16;
      CAG_MODE_SHORT, CAG_MODE_SHORT_WORD:
      begin
        addr_d = {CAG_SHORT_HIGH, req_imm16[7:0] < CAG_SHORT_SPLIT,
                  req_imm16[7:0]};
        fault_d = (req_mode == CAG_MODE_SHORT_WORD) && req_imm16[0];
      end
      CAG_MODE_SFR, CAG_MODE_SFR_WORD:
      begin
        addr_d = {CAG_SFR_HIGH, req_imm16[7:0]};
        fault_d = (req_imm16[7:0] >= CAG_SFR_GAP_LO &&
                   req_imm16[7:0] <= CAG_SFR_GAP_HI) ||
                  (req_mode == CAG_MODE_SFR_WORD && req_imm16[0]);
      end
      CAG_MODE_IND_DE: addr_d = second_ptr_pair;
      CAG_MODE_IND_HL: addr_d = base_pair;
      CAG_MODE_BASED:
        addr_d = 16'(base_pair + {8'h00, req_imm16[7:0]});
      CAG_MODE_BASED_IDX_B:
        addr_d = 16'(base_pair + {8'h00, regs_q[reg_index(rbank, CAG_REG_B)]});
      CAG_MODE_BASED_IDX_C:
        addr_d = 16'(base_pair + {8'h00, regs_q[reg_index(rbank, CAG_REG_C)]});
      CAG_MODE_STACK:
      begin
        addr_d = stack_pointer;
        fault_d = (stack_pointer < CAG_HRAM_LO) ||
                  (stack_pointer > CAG_HRAM_HI);
      end
      CAG_MODE_TABLE:
        addr_d = CAG_TABLE_BASE | {10'h000, req_opcode[5:1], 1'b0};
      default: fault_d = 1'b1;
    endcase
  end

  // Operand and fetch addresses share one mapper design, two instances.
  cag_bank_map u_op_map (
    .logical_addr(addr_d),
    .bank_sel(bank_q),
    .phys_addr(addr_phys_d),
    .in_window()
  );

  cag_bank_map u_fetch_map (
    .logical_addr(pc_d),
    .bank_sel(bank_q),
    .phys_addr(fetch_phys_d),
    .in_window()
  );

  // Operand answer registers; valid repeats req_valid one cycle later.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      addr_valid_q <= 1'b0;
      addr_q <= 16'h0000;
      addr_phys_q <= 17'h00000;
      addr_fault_q <= 1'b0;
    end
    else
    begin
      addr_valid_q <= req_valid;
      addr_fault_q <= req_valid && fault_d;
      if (req_valid)
      begin
        addr_q <= addr_d;
        addr_phys_q <= addr_phys_d;
      end
    end
  end

  // Next program counter: jump over table load over sequential step.
  always_comb
  begin
    fetch_end = 16'(program_counter_q + {13'h0000, pc_step_len} - 16'h0001);
    fetch_fault_d = 1'b0;
    if (jump_instr)
    begin
      pc_d = pair_ax;
    end
    else if (table_load_valid)
    begin
      pc_d = table_data;
    end
    else if (pc_step_valid)
    begin
      pc_d = 16'(program_counter_q + {13'h0000, pc_step_len});
      // A fetch that runs from the common area into the window is only
      // safe while bank 0 is in place; otherwise the bytes would mix.
      fetch_fault_d = (program_counter_q < CAG_WIN_LO) &&
                      (fetch_end >= CAG_WIN_LO) &&
                      (bank_q != CAG_BANK_RESET);
    end
    else
    begin
      pc_d = program_counter_q;
    end
  end

  // Program counter and fetch address.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      program_counter_q <= CAG_PC_RESET;
      fetch_phys_q <= {1'b0, CAG_PC_RESET};
      fetch_fault_q <= 1'b0;
    end
    else
    begin
      program_counter_q <= pc_d;
      fetch_phys_q <= fetch_phys_d;
      fetch_fault_q <= fetch_fault_d;
    end
  end

  // Bank select; only three bits exist, the rest read as zero. Software
  // is trusted to write codes 0 to 3 from the common area.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bank_q <= CAG_BANK_RESET;
    end
    else if (bank_wr_valid)
    begin
      bank_q <= bank_wr_data[2:0];
    end
  end

  property p_table;
    @(posedge sys_clk) disable iff (!reset_n)
    req_valid && req_mode == CAG_MODE_TABLE |=>
      addr_q >= 16'h0040 && addr_q <= 16'h007e && !addr_q[0];
  endproperty
  a_table: assert property (p_table) else $error("table address out of range");

  property p_jump;
    @(posedge sys_clk) disable iff (!reset_n)
    jump_instr |=> program_counter_q == $past(pair_ax);
  endproperty
  a_jump: assert property (p_jump) else $error("jump did not load pair");

  property p_mul;
    @(posedge sys_clk) disable iff (!reset_n)
    imp_wr_valid && imp_wr_op == CAG_IMP_MULTIPLY ##1 $stable(rbank)
      |-> pair_ax == $past(imp_wr_data);
  endproperty
  a_mul: assert property (p_mul) else $error("product not in pair");

  property p_adj;
    @(posedge sys_clk) disable iff (!reset_n)
    imp_wr_valid && imp_wr_op == CAG_IMP_BCD_ADD ##1 $stable(rbank)
      |-> pair_ax == {$past(imp_wr_data[7:0]), $past(pair_ax[7:0])};
  endproperty
  a_adj: assert property (p_adj) else $error("adjust touched wrong byte");

  property p_short;
    @(posedge sys_clk) disable iff (!reset_n)
    req_valid && req_mode == CAG_MODE_SHORT |=>
      addr_q[8] == ($past(req_imm16[7:0]) < 8'h20) &&
      addr_q >= 16'hfe20 && addr_q <= 16'hff1f;
  endproperty
  a_short: assert property (p_short) else $error("short address wrong");

  property p_based;
    @(posedge sys_clk) disable iff (!reset_n)
    req_valid && req_mode == CAG_MODE_BASED |=>
      addr_q == 16'($past(base_pair) + {8'h00, $past(req_imm16[7:0])});
  endproperty
  a_based: assert property (p_based) else $error("based sum wrong");

  property p_stack;
    @(posedge sys_clk) disable iff (!reset_n)
    req_valid && req_mode == CAG_MODE_STACK |=>
      addr_fault_q == ($past(stack_pointer) < 16'hfb00 ||
                       $past(stack_pointer) > 16'hfeff);
  endproperty
  a_stack: assert property (p_stack) else $error("stack fault wrong");

  property p_window;
    @(posedge sys_clk) disable iff (!reset_n)
    addr_valid_q && addr_q[15:14] == 2'b10 |->
      addr_phys_q == 17'h08000 + {1'b0, $past(bank_q[1:0]), addr_q[13:0]};
  endproperty
  a_window: assert property (p_window) else $error("bank map wrong");

  property p_fetch;
    @(posedge sys_clk) disable iff (!reset_n)
    fetch_fault_q |-> $past(bank_q) != 3'h0 &&
      $past(program_counter_q) < 16'h8000 && program_counter_q > 16'h8000;
  endproperty
  a_fetch: assert property (p_fetch) else $error("false fetch fault");

  c_window: cover property (@(posedge sys_clk) disable iff (!reset_n)
    addr_valid_q && addr_q[15:14] == 2'b10 && bank_q == 3'h3);
  c_fetch: cover property (@(posedge sys_clk) disable iff (!reset_n)
    fetch_fault_q);
  c_sfr_gap: cover property (@(posedge sys_clk) disable iff (!reset_n)
    addr_fault_q && addr_q[15:8] == 8'hff);

endmodule

// *** verification/cag_mem_model.sv ***
// Table memory model that answers table-entry reads for the address unit.
`timescale 1ns/10ps
module cag_mem_model #(
  parameter int LATENCY = 3
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Read request
  input wire logic rd_valid,
  input wire logic [15:0] rd_addr,
  // Read answer
  output logic ld_valid,
  output logic [15:0] ld_data
);
  int wait_q;
  logic [15:0] addr_q;

  // Entries in 40H to 7FH hold a word made from the entry address. Between
  // answers the data toggles, so a stale word is never mistaken for fresh.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wait_q <= 0;
      addr_q <= 16'h0000;
      ld_valid <= 1'b0;
      ld_data <= 16'h0000;
    end
    else if (rd_valid)
    begin
      addr_q <= rd_addr;
      wait_q <= LATENCY;
      ld_valid <= 1'b0;
      ld_data <= ~ld_data;
    end
    else if (wait_q == 1)
    begin
      wait_q <= 0;
      ld_valid <= 1'b1;
      ld_data <= {8'ha5, addr_q[7:0]};
    end
    else
    begin
      wait_q <= (wait_q > 0) ? wait_q - 1 : 0;
      ld_valid <= 1'b0;
      ld_data <= ~ld_data;
    end
  end
endmodule

// *** verification/cag_addr_gen_test.sv ***
// Self-checking bench for the CPU address generation block.
`timescale 1ns/10ps
module cag_addr_gen_test;
  import cag_pkg::*;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic reg_bank_sel_lo = 1'b0;
  logic reg_bank_sel_hi = 1'b0;
  logic req_valid = 1'b0;
  cag_mode_type req_mode = CAG_MODE_DIRECT;
  logic [7:0] req_opcode = 8'h00;
  logic [15:0] req_imm16 = 16'h0000;
  logic [15:0] stack_pointer = 16'hfb00;
  logic addr_valid_q, addr_fault_q, fetch_fault_q, table_load_valid;
  logic [15:0] addr_q, acc_word_pair_q, program_counter_q, table_data;
  logic [16:0] addr_phys_q, fetch_phys_q;
  logic reg_wr_valid = 1'b0;
  logic [2:0] reg_wr_code = 3'h0;
  logic [7:0] reg_wr_data = 8'h00;
  logic [2:0] reg_rd_code = 3'h0;
  logic [7:0] reg_rd_data_q, acc_byte_q;
  logic imp_wr_valid = 1'b0;
  cag_imp_type imp_wr_op = CAG_IMP_MULTIPLY;
  logic [15:0] imp_wr_data = 16'h0000;
  logic jump_instr = 1'b0;
  logic pc_step_valid = 1'b0;
  logic [2:0] pc_step_len = 3'h0;
  logic bank_wr_valid = 1'b0;
  logic [7:0] bank_wr_data = 8'h00;
  logic [2:0] bank_q;
  logic tbl_rd = 1'b0;
  int n_mismatch = 0;
  int checks_done = 0;

  cag_addr_gen dut_u (.*);

  cag_mem_model mem_u (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .rd_valid(tbl_rd),
    .rd_addr(addr_q),
    .ld_valid(table_load_valid),
    .ld_data(table_data)
  );

  // Free-running 50 MHz clock.
  always #10 sys_clk = ~sys_clk;

  task automatic tally_and_finish();
    if (n_mismatch == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [16:0] exp, input logic [16:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // Inputs change 1 ns after the edge so sampling never races.
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic req(input cag_mode_type m, input logic [7:0] op,
    input logic [15:0] imm, input logic [15:0] ea, input logic flt);
    req_mode = m;
    req_opcode = op;
    req_imm16 = imm;
    req_valid = 1'b1;
    tick();
    req_valid = 1'b0;
    chk(17'h1, 17'(addr_valid_q));
    chk(17'(ea), 17'(addr_q));
    chk(17'(flt), 17'(addr_fault_q));
    tick();
  endtask

  task automatic wr_reg(input logic [2:0] c, input logic [7:0] d);
    reg_wr_code = c;
    reg_wr_data = d;
    reg_wr_valid = 1'b1;
    tick();
    reg_wr_valid = 1'b0;
    tick();
  endtask

  task automatic imp(input cag_imp_type op, input logic [15:0] d);
    imp_wr_op = op;
    imp_wr_data = d;
    imp_wr_valid = 1'b1;
    tick();
    imp_wr_valid = 1'b0;
    tick();
    tick();
  endtask

  task automatic set_bank(input logic [7:0] b);
    bank_wr_data = b;
    bank_wr_valid = 1'b1;
    tick();
    bank_wr_valid = 1'b0;
    tick();
  endtask

  // One pulse on jump or step; outputs are checked right after the edge.
  task automatic pc_go(input logic j, input logic [2:0] len);
    jump_instr = j;
    pc_step_valid = !j;
    pc_step_len = len;
    tick();
    jump_instr = 1'b0;
    pc_step_valid = 1'b0;
  endtask

  task automatic t_regs();
    for (int b = 0; b < 4; b++)
    begin
      {reg_bank_sel_hi, reg_bank_sel_lo} = 2'(b);
      for (int c = 0; c < 8; c++)
        wr_reg(3'(c), 8'(16 * b + 48 + c));
    end
    for (int b = 0; b < 4; b++)
    begin
      {reg_bank_sel_hi, reg_bank_sel_lo} = 2'(b);
      for (int c = 0; c < 8; c++)
      begin
        reg_rd_code = 3'(c);
        tick();
        tick();
        chk(17'(16 * b + 48 + c), 17'(reg_rd_data_q));
      end
    end
    // Bank 3 now holds X..H = 60H..67H, so DE = 6564H and HL = 6766H.
    req(CAG_MODE_IND_DE, 8'h00, 16'h0000, 16'h6564, 1'b0);
    req(CAG_MODE_IND_HL, 8'h00, 16'h0000, 16'h6766, 1'b0);
    req(CAG_MODE_BASED, 8'h00, 16'h0010, 16'h6776, 1'b0);
    req(CAG_MODE_BASED_IDX_B, 8'h00, 16'h0, 16'h67c9, 1'b0);
    req(CAG_MODE_BASED_IDX_C, 8'h00, 16'h0, 16'h67c8, 1'b0);
    pc_go(1'b1, 3'h0);
    chk(17'h06160, 17'(program_counter_q));
    tick();
    wr_reg(CAG_REG_H, 8'hff);
    wr_reg(CAG_REG_L, 8'hf0);
    req(CAG_MODE_BASED, 8'h00, 16'h00ff, 16'h00ef, 1'b0);
    req(CAG_MODE_BASED_IDX_B, 8'h00, 16'h0, 16'h0053, 1'b0);
  endtask

  task automatic t_implied();
    logic [15:0] ew;
    ew = 16'h6160;
    for (int k = 0; k < 6; k++)
    begin
      if (k < 2)
        ew = 16'h1234 + 16'(k) * 16'h1111;
      else
        ew[15:8] = 8'h34 + 8'(k) * 8'h11;
      imp(cag_imp_type'(k), 16'h1234 + 16'(k) * 16'h1111);
      chk(17'(ew), 17'(acc_word_pair_q));
      chk(17'(ew[15:8]), 17'(acc_byte_q));
    end
  endtask

  task automatic t_modes();
    req(CAG_MODE_DIRECT, 8'h00, 16'hfe00, 16'hfe00, 1'b0);
    req(CAG_MODE_SHORT, 8'h00, 16'h0020, 16'hfe20, 1'b0);
    req(CAG_MODE_SHORT, 8'h00, 16'h00ff, 16'hfeff, 1'b0);
    req(CAG_MODE_SHORT, 8'h00, 16'h001f, 16'hff1f, 1'b0);
    req(CAG_MODE_SHORT, 8'h00, 16'h0000, 16'hff00, 1'b0);
    req(CAG_MODE_SHORT_WORD, 8'h00, 16'h0030, 16'hfe30, 1'b0);
    req(CAG_MODE_SHORT_WORD, 8'h00, 16'h0031, 16'hfe31, 1'b1);
    req(CAG_MODE_SFR, 8'h00, 16'h0020, 16'hff20, 1'b0);
    req(CAG_MODE_SFR, 8'h00, 16'h00d5, 16'hffd5, 1'b1);
    req(CAG_MODE_SFR, 8'h00, 16'h00e0, 16'hffe0, 1'b0);
    req(CAG_MODE_SFR_WORD, 8'h00, 16'h00e1, 16'hffe1, 1'b1);
    req(CAG_MODE_SFR_WORD, 8'h00, 16'h00e0, 16'hffe0, 1'b0);
    req(CAG_MODE_STACK, 8'h00, 16'h0, 16'hfb00, 1'b0);
    stack_pointer = 16'hfeff;
    req(CAG_MODE_STACK, 8'h00, 16'h0, 16'hfeff, 1'b0);
    stack_pointer = 16'hfaff;
    req(CAG_MODE_STACK, 8'h00, 16'h0, 16'hfaff, 1'b1);
    stack_pointer = 16'hff00;
    req(CAG_MODE_STACK, 8'h00, 16'h0, 16'hff00, 1'b1);
  endtask

  task automatic t_table();
    int i;
    req(CAG_MODE_TABLE, 8'hc1, 16'h0, 16'h0040, 1'b0);
    req(CAG_MODE_TABLE, 8'h3e, 16'h0, 16'h007e, 1'b0);
    tbl_rd = 1'b1;
    tick();
    tbl_rd = 1'b0;
    for (i = 0; i < 10 && table_load_valid !== 1'b1; i++)
      tick();
    if (i == 10)
    begin
      n_mismatch++;
      tally_and_finish();
    end
    tick();
    chk(17'h0a57e, 17'(program_counter_q));
  endtask

  task automatic t_bank();
    for (int b = 0; b < 4; b++)
    begin
      set_bank(8'(b));
      chk(17'(b), 17'(bank_q));
      req(CAG_MODE_DIRECT, 8'h00, 16'h9234, 16'h9234, 1'b0);
      chk(17'h08000 + {b[1:0], 14'h1234}, addr_phys_q);
    end
    req(CAG_MODE_DIRECT, 8'h00, 16'h4321, 16'h4321, 1'b0);
    chk(17'h04321, addr_phys_q);
    imp(CAG_IMP_MULTIPLY, 16'h7ffe);
    for (int b = 1; b >= 0; b--)
    begin
      set_bank(8'(b));
      pc_go(1'b1, 3'h0);
      tick();
      pc_go(1'b0, 3'h3);
      chk(17'h08001, 17'(program_counter_q));
      chk(17'(b), 17'(fetch_fault_q));
      chk(17'h08000 + {b[1:0], 14'h0001}, fetch_phys_q);
      tick();
    end
    // A mid-run reset must drop a non-zero bank back to bank 0.
    set_bank(8'h03);
    chk(17'h3, 17'(bank_q));
    reset_n = 1'b0;
    tick();
    chk(17'h0, 17'(bank_q));
    chk(17'h0, 17'(program_counter_q));
    reset_n = 1'b1;
    tick();
    chk(17'h0, 17'(bank_q));
  endtask

  // Main sequence: reset for three cycles, then each scenario in turn.
  initial
  begin
    repeat (3) @(posedge sys_clk);
    #1;
    chk(17'h0, 17'(bank_q));
    reset_n = 1'b1;
    tick();
    t_regs();
    t_implied();
    t_modes();
    t_table();
    t_bank();
    tally_and_finish();
  end
endmodule
